/* File: bench/nsf_feature_table_tb.sv */
// Purpose: self-checking bench of the feature register bank
// Assumes: host model drives the link, bench drives wp pin and core status
// Notes: read bytes are checked against a queue of expected values
`timescale 1ns/1ps
module nsf_feature_table_tb;
    import nsf_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cs_n, sck, si, so, so_oe_n, reset_cmd, rx_stb;
    logic write_protect_n = 1'b1;
    logic [7:0] rx_byte;
    logic [7:0] rnd = 8'h16;
    logic [7:0] exp_q[$];
    nsf_core_stat_t core_stat = '0;
    nsf_cfg_t cfg;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int rst_seen = 0;

    always #20 clk_sys = ~clk_sys;

    nsf_feature_table i_nsf_feature_table (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n),
        .sck(sck), .si(si), .write_protect_n(write_protect_n), .so(so), .so_oe_n(so_oe_n),
        .core_stat(core_stat), .cfg(cfg), .reset_cmd(reset_cmd));
    nsf_host_model i_nsf_host_model (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si),
        .so(so), .rx_byte(rx_byte), .rx_stb(rx_stb));

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : chk

    task automatic chk_cfg(input nsf_cfg_t e);
        samples_checked++;
        if (cfg !== e) begin
            num_errors++;
            $display("wrong value cfg expected %h seen %h", e, cfg);
        end
    endtask : chk_cfg

    // note the expectation first, then let the host read it
    task automatic rd(input logic [7:0] addr, input logic [7:0] e, input int n = 1);
        repeat (n) exp_q.push_back(e);
        i_nsf_host_model.get_feat(addr, n);
    endtask : rd

    // result watcher: every byte read off the link takes the oldest note
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (reset_cmd === 1'b1) begin
            rst_seen <= rst_seen + 1;
        end
        if (rx_stb === 1'b1) begin
            chk("feature byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rx_byte);
        end
        if (cyc == 40000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk_cfg(NSF_CFG_RESET);
        rd(NSF_OFS_LOCK, 8'h38);
        rd(NSF_OFS_CONFIG, 8'h16);
        rd(NSF_OFS_FLIP_THRESHOLD, 8'h00);
        rd(NSF_OFS_STATUS, 8'h00);
        // every lock range, reserved bits written with noise
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            i_nsf_host_model.set_feat(NSF_OFS_LOCK, {1'b0, rnd[6], k[2:0], rnd[2:0]});
            rd(NSF_OFS_LOCK, {2'b00, k[2:0], 3'b000});
            chk("lock range", {5'h00, k[2:0]}, {5'h00, cfg.lock_range});
        end
        // random settings: stored bits read back, reserved zero, inhibit stays 1
        repeat (4) begin
            rnd = lfsr(rnd);
            i_nsf_host_model.set_feat(NSF_OFS_CONFIG, rnd);
            rd(NSF_OFS_CONFIG, {rnd[7:6], 1'b0, rnd[4], 2'b01, rnd[1], 1'b0});
            chk("cfg bits", {4'h0, rnd[7], rnd[6], rnd[4], rnd[1]}, {4'h0, cfg.protect_enable,
                cfg.id_read_enable, cfg.ecc_enable, cfg.fast_read_enable});
            i_nsf_host_model.set_feat(NSF_OFS_FLIP_THRESHOLD, ~rnd);
            rd(NSF_OFS_FLIP_THRESHOLD, {~rnd[7:4], 4'h0});
        end
        // latch ignores set-feature, follows only its own opcodes
        i_nsf_host_model.cmd(NSF_OP_WR_EN);
        rd(NSF_OFS_STATUS, 8'h02);
        i_nsf_host_model.set_feat(NSF_OFS_STATUS, 8'h00);
        rd(NSF_OFS_STATUS, 8'h02);
        i_nsf_host_model.cmd(NSF_OP_WR_DIS);
        i_nsf_host_model.set_feat(NSF_OFS_STATUS, 8'hff);
        rd(NSF_OFS_STATUS, 8'h00);
        // reset opcodes leave settings alone
        i_nsf_host_model.set_feat(NSF_OFS_CONFIG, 8'h00);
        i_nsf_host_model.cmd(NSF_OP_RESET_A);
        i_nsf_host_model.cmd(NSF_OP_RESET_B);
        chk("reset pulses", 8'h02, rst_seen[7:0]);
        rd(NSF_OFS_CONFIG, 8'h04);
        rd(NSF_OFS_LOCK, 8'h38);
        // guard with wp low freezes guard and range; wp high frees them
        i_nsf_host_model.set_feat(NSF_OFS_LOCK, 8'h88);
        write_protect_n = 1'b0;
        i_nsf_host_model.set_feat(NSF_OFS_LOCK, 8'h30);
        rd(NSF_OFS_LOCK, 8'h88);
        write_protect_n = 1'b1;
        i_nsf_host_model.set_feat(NSF_OFS_LOCK, 8'h30);
        write_protect_n = 1'b0;
        i_nsf_host_model.set_feat(NSF_OFS_LOCK, 8'h10);
        rd(NSF_OFS_LOCK, 8'h10);
        write_protect_n = 1'b1;
        // every correction code with random fail bits
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            core_stat.correction_status = k[1:0];
            core_stat.program_fail = rnd[0];
            core_stat.erase_fail = rnd[1];
            rd(NSF_OFS_STATUS, {2'b00, k[1:0], rnd[0], rnd[1], 2'b00});
        end
        core_stat = '0;
        core_stat.busy = 1'b1;
        rd(NSF_OFS_STATUS, 8'h01, 3);
        core_stat.busy = 1'b0;
        // read-only statistics show core values and ignore writes
        rnd = lfsr(rnd);
        core_stat.flip_sector_flags = rnd;
        core_stat.max_flip_count = rnd[7:4];
        core_stat.max_flip_sector = rnd[2:0];
        core_stat.flip_report = {rnd[5:0], ~rnd, rnd, ~rnd};
        i_nsf_host_model.set_feat(NSF_OFS_FLIP_SECTOR, ~rnd);
        rd(NSF_OFS_FLIP_SECTOR, rnd);
        rd(NSF_OFS_MAX_FLIP, {rnd[7:4], 1'b0, rnd[2:0]});
        rd(NSF_OFS_REPORT0, ~rnd);
        rd(NSF_OFS_REPORT1, rnd);
        rd(NSF_OFS_REPORT2, ~rnd);
        rd(NSF_OFS_REPORT3, {2'b00, rnd[5:0]});
        chk("so enable", 8'h01, {7'h00, so_oe_n});
        chk("queue left", 8'h00, exp_q.size());
        close_out();
    end
endmodule : nsf_feature_table_tb

/* File: bench/nsf_host_model.sv */
// Purpose: host controller on the serial flash link, mode 0 framing
// Assumes: sck half period of 4 clk_sys cycles, 320 ns per bit
// Notes: sck rests low between frames; si flips on release so stale data never looks valid
`timescale 1ns/1ps
module nsf_host_model (
    input wire logic clk_sys,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    import nsf_pkg::*;

    // idle pins at time zero
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
    end

    // so is taken at the rise, a full half period after the fall that moved it
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            repeat (4) @(negedge clk_sys);
            rx[i] = so;
            sck = 1'b1;
            repeat (4) @(negedge clk_sys);
            sck = 1'b0;
        end
    endtask : xbyte

    task automatic open_frame();
        cs_n = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : open_frame

    // gap after cs_n rises is longer than the sync needs
    task automatic close_frame();
        repeat (4) @(negedge clk_sys);
        cs_n = 1'b1;
        si = ~si;
        repeat (8) @(negedge clk_sys);
    endtask : close_frame

    // single opcode frame, latch moves only this way
    task automatic cmd(input logic [7:0] op);
        logic [7:0] rx;
        open_frame();
        xbyte(op, rx);
        close_frame();
    endtask : cmd

    task automatic set_feat(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        open_frame();
        xbyte(NSF_OP_SET_FEAT, rx);
        xbyte(addr, rx);
        xbyte(data, rx);
        close_frame();
    endtask : set_feat

    // reads n repeats of the addressed byte before raising cs_n
    task automatic get_feat(input logic [7:0] addr, input int n);
        logic [7:0] rx;
        open_frame();
        xbyte(NSF_OP_GET_FEAT, rx);
        xbyte(addr, rx);
        repeat (n) begin
            xbyte(8'h00, rx);
            rx_byte = rx;
            rx_stb = 1'b1;
            @(negedge clk_sys);
            rx_stb = 1'b0;
        end
        close_frame();
    endtask : get_feat
endmodule : nsf_host_model

/* File: include/nsf_pkg.sv */
// Purpose: shared constants and types of the serial flash feature table
// Assumes: one byte per feature register, serial opcode/address/data framing
// Notes: offsets are the feature addresses seen on the serial link
package nsf_pkg;
    // serial opcodes
    localparam logic [7:0] NSF_OP_SET_FEAT = 8'h1f;
    localparam logic [7:0] NSF_OP_GET_FEAT = 8'h0f;
    localparam logic [7:0] NSF_OP_WR_EN = 8'h06;
    localparam logic [7:0] NSF_OP_WR_DIS = 8'h04;
    localparam logic [7:0] NSF_OP_RESET_A = 8'hff;
    localparam logic [7:0] NSF_OP_RESET_B = 8'hfe;
    // feature addresses
    localparam logic [7:0] NSF_OFS_FLIP_THRESHOLD = 8'h10;
    localparam logic [7:0] NSF_OFS_FLIP_SECTOR = 8'h20;
    localparam logic [7:0] NSF_OFS_MAX_FLIP = 8'h30;
    localparam logic [7:0] NSF_OFS_REPORT0 = 8'h40;
    localparam logic [7:0] NSF_OFS_REPORT1 = 8'h50;
    localparam logic [7:0] NSF_OFS_REPORT2 = 8'h60;
    localparam logic [7:0] NSF_OFS_REPORT3 = 8'h70;
    localparam logic [7:0] NSF_OFS_LOCK = 8'ha0;
    localparam logic [7:0] NSF_OFS_CONFIG = 8'hb0;
    localparam logic [7:0] NSF_OFS_STATUS = 8'hc0;
    // field positions
    localparam int NSF_LOCK_GUARD_BIT = 7;
    localparam int NSF_LOCK_RANGE_LSB = 3;
    localparam int NSF_CFG_PROTECT_BIT = 7;
    localparam int NSF_CFG_ID_READ_BIT = 6;
    localparam int NSF_CFG_ECC_BIT = 4;
    localparam int NSF_CFG_BBI_BIT = 2;
    localparam int NSF_CFG_FAST_BIT = 1;
    localparam int NSF_STAT_CORR_LSB = 4;
    localparam int NSF_STAT_PRG_BIT = 3;
    localparam int NSF_STAT_ERS_BIT = 2;
    localparam int NSF_STAT_WEL_BIT = 1;
    localparam int NSF_STAT_BUSY_BIT = 0;
    localparam int NSF_THRESH_LSB = 4;
    localparam int NSF_MAXFLIP_LSB = 4;
    // counts and constant readings
    localparam logic [2:0] NSF_LAST_BIT = 3'h7;
    localparam logic NSF_BBI_VALUE = 1'b1;
    localparam logic [3:0] NSF_PIN_RESET = 4'h9; // cs_n high, sck low, si low, wp_n high

    typedef enum logic [2:0] {
        NSF_IDLE = 3'b000,
        NSF_OPCODE = 3'b001,
        NSF_ADDR_WR = 3'b010,
        NSF_ADDR_RD = 3'b011,
        NSF_WDATA = 3'b100,
        NSF_RDATA = 3'b101,
        NSF_SKIP = 3'b110
    } nsf_state_t;

    // values kept by the rest of the device
    typedef struct packed {
        logic busy;
        logic [1:0] correction_status;
        logic program_fail;
        logic erase_fail;
        logic [7:0] flip_sector_flags;
        logic [3:0] max_flip_count;
        logic [2:0] max_flip_sector;
        logic [29:0] flip_report;
    } nsf_core_stat_t;

    // settings written over the link
    typedef struct packed {
        logic lock_write_guard;
        logic [2:0] lock_range;
        logic protect_enable;
        logic id_read_enable;
        logic ecc_enable;
        logic fast_read_enable;
        logic [3:0] flip_threshold;
        logic write_enable_latch;
    } nsf_cfg_t;

    localparam nsf_cfg_t NSF_CFG_RESET = '{
        lock_write_guard: 1'b0,
        lock_range: 3'h7,
        protect_enable: 1'b0,
        id_read_enable: 1'b0,
        ecc_enable: 1'b1,
        fast_read_enable: 1'b1,
        flip_threshold: 4'h0,
        write_enable_latch: 1'b0
    };
endpackage : nsf_pkg

/* File: rtl/nsf_feature_table.sv */
// Purpose: feature and status register bank behind the serial flash pins
// Assumes: host runs mode 0 framing; core status comes from clk_sys logic
// Notes: settings survive the reset opcode and clear only on sys_rst
//
// How it works
// - opcode 1Fh writes one addressed feature byte, 0Fh reads it back
// - written settings stay until sys_rst; the reset opcode leaves them
// - write-enable latch moves only with 06h and 04h, never by a write
// - read-only fields ignore writes and show device values; others store
// - lock range bits 5..3 of A0h, 000 none, 111 all locked, default
// - with write protect low and guard set, guard and range refuse writes
// - B0h bit 7 protect enable, default 0, allows protect-execute
// - B0h bit 6 selects identifier page read mode, default 0
// - B0h bit 4 enables internal correction, default on
// - B0h bit 2 read-only bad-block inhibit, reads 1
// - B0h bit 1 enables fast page read, default on
// - C0h bits 5..4 report correction status from the core
// - C0h bit 0 reads 1 while busy, 0 when ready
// - program and erase fail bits report the last operation result
// - read repeats the addressed byte, busy live, until chip select rises
`timescale 1ns/1ps
module nsf_feature_table (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic write_protect_n,
    output logic so,
    output logic so_oe_n,
    input wire nsf_pkg::nsf_core_stat_t core_stat,
    output nsf_pkg::nsf_cfg_t cfg,
    output logic reset_cmd
);
    import nsf_pkg::*;

    logic [3:0] pins_sync;
    logic cs_active;
    logic wp_low;
    logic [7:0] rx_byte;
    logic byte_done;
    logic tx_bit;
    logic wr_strobe;
    logic guard_locked;
    logic [7:0] rd_byte;
    nsf_state_t state;
    nsf_state_t next_state;
    logic [7:0] addr;
    logic [7:0] next_addr;
    nsf_cfg_t next_cfg;
    logic next_reset_cmd;
    logic next_so_oe_n;

    // all pins cross into clk_sys before anything looks at them
    nsf_sync #(
        .WIDTH(4),
        .RESET_VAL(NSF_PIN_RESET)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({cs_n, sck, si, write_protect_n}),
        .sync_out(pins_sync)
    );

    assign cs_active = !pins_sync[3];
    assign wp_low = !pins_sync[0];

    nsf_shifter u_shifter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .frame_active(cs_active),
        .sck_level(pins_sync[2]),
        .si_level(pins_sync[1]),
        .tx_load_en(state == NSF_RDATA),
        .tx_load_byte(rd_byte),
        .rx_byte(rx_byte),
        .byte_done(byte_done),
        .tx_bit(tx_bit)
    );

    assign so = tx_bit;
    assign wr_strobe = (state == NSF_WDATA) && byte_done;
    assign guard_locked = cfg.lock_write_guard && wp_low;

    // read view; status is built live so repeated bytes track busy
    always_comb begin
        rd_byte = 8'h00; // unmapped and reserved read zero
        case (addr)
            NSF_OFS_LOCK: begin
                rd_byte[NSF_LOCK_GUARD_BIT] = cfg.lock_write_guard;
                rd_byte[NSF_LOCK_RANGE_LSB +: 3] = cfg.lock_range;
            end
            NSF_OFS_CONFIG: begin
                rd_byte[NSF_CFG_PROTECT_BIT] = cfg.protect_enable;
                rd_byte[NSF_CFG_ID_READ_BIT] = cfg.id_read_enable;
                rd_byte[NSF_CFG_ECC_BIT] = cfg.ecc_enable;
                rd_byte[NSF_CFG_BBI_BIT] = NSF_BBI_VALUE;
                rd_byte[NSF_CFG_FAST_BIT] = cfg.fast_read_enable;
            end
            NSF_OFS_STATUS: begin
                rd_byte[NSF_STAT_CORR_LSB +: 2] = core_stat.correction_status;
                rd_byte[NSF_STAT_PRG_BIT] = core_stat.program_fail;
                rd_byte[NSF_STAT_ERS_BIT] = core_stat.erase_fail;
                rd_byte[NSF_STAT_WEL_BIT] = cfg.write_enable_latch;
                rd_byte[NSF_STAT_BUSY_BIT] = core_stat.busy;
            end
            NSF_OFS_FLIP_THRESHOLD: rd_byte[NSF_THRESH_LSB +: 4] = cfg.flip_threshold;
            NSF_OFS_FLIP_SECTOR: rd_byte = core_stat.flip_sector_flags;
            NSF_OFS_MAX_FLIP: begin
                rd_byte[NSF_MAXFLIP_LSB +: 4] = core_stat.max_flip_count;
                rd_byte[2:0] = core_stat.max_flip_sector;
            end
            NSF_OFS_REPORT0: rd_byte = core_stat.flip_report[7:0];
            NSF_OFS_REPORT1: rd_byte = core_stat.flip_report[15:8];
            NSF_OFS_REPORT2: rd_byte = core_stat.flip_report[23:16];
            NSF_OFS_REPORT3: rd_byte[5:0] = core_stat.flip_report[29:24];
            default: rd_byte = 8'h00;
        endcase
    end

    // frame decoder and register writes; while busy only reads and reset act
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_cfg = cfg;
        next_reset_cmd = 1'b0;
        if (!cs_active) begin
            next_state = NSF_IDLE;
        end else begin
            case (state)
                NSF_IDLE: begin
                    next_state = NSF_OPCODE;
                end
                NSF_OPCODE: begin
                    if (byte_done) begin
                        next_state = NSF_SKIP;
                        case (rx_byte)
                            NSF_OP_SET_FEAT: begin
                                if (!core_stat.busy) begin
                                    next_state = NSF_ADDR_WR;
                                end
                            end
                            NSF_OP_GET_FEAT: next_state = NSF_ADDR_RD;
                            NSF_OP_WR_EN: begin
                                if (!core_stat.busy) begin
                                    next_cfg.write_enable_latch = 1'b1;
                                end
                            end
                            NSF_OP_WR_DIS: begin
                                if (!core_stat.busy) begin
                                    next_cfg.write_enable_latch = 1'b0;
                                end
                            end
                            // settings deliberately untouched
                            NSF_OP_RESET_A: next_reset_cmd = 1'b1;
                            NSF_OP_RESET_B: next_reset_cmd = 1'b1;
                            default: next_state = NSF_SKIP;
                        endcase
                    end
                end
                NSF_ADDR_WR: begin
                    if (byte_done) begin
                        next_addr = rx_byte;
                        next_state = NSF_WDATA;
                    end
                end
                NSF_ADDR_RD: begin
                    if (byte_done) begin
                        next_addr = rx_byte;
                        next_state = NSF_RDATA;
                    end
                end
                NSF_WDATA: begin
                    if (byte_done) begin
                        next_state = NSF_SKIP;
                    end
                end
                NSF_RDATA: next_state = NSF_RDATA;
                NSF_SKIP: next_state = NSF_SKIP;
                default: next_state = NSF_IDLE;
            endcase
        end
        // only writable fields are picked out; the rest is ignored
        if (wr_strobe) begin
            case (addr)
                NSF_OFS_LOCK: begin
                    if (!guard_locked) begin
                        next_cfg.lock_write_guard = rx_byte[NSF_LOCK_GUARD_BIT];
                        next_cfg.lock_range = rx_byte[NSF_LOCK_RANGE_LSB +: 3];
                    end
                end
                NSF_OFS_CONFIG: begin
                    next_cfg.protect_enable = rx_byte[NSF_CFG_PROTECT_BIT];
                    next_cfg.id_read_enable = rx_byte[NSF_CFG_ID_READ_BIT];
                    next_cfg.ecc_enable = rx_byte[NSF_CFG_ECC_BIT];
                    next_cfg.fast_read_enable = rx_byte[NSF_CFG_FAST_BIT];
                end
                NSF_OFS_FLIP_THRESHOLD: begin
                    next_cfg.flip_threshold = rx_byte[NSF_THRESH_LSB +: 4];
                end
                default: next_cfg = next_cfg;
            endcase
        end
        next_so_oe_n = (next_state != NSF_RDATA); // drive only in the read phase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= NSF_IDLE;
            addr <= 8'h00;
            cfg <= NSF_CFG_RESET;
            reset_cmd <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            addr <= next_addr;
            cfg <= next_cfg;
            reset_cmd <= next_reset_cmd;
            so_oe_n <= next_so_oe_n;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_wel_set_cmd: assert property (
        state == NSF_OPCODE && byte_done && rx_byte == NSF_OP_WR_EN && !core_stat.busy
        |=> cfg.write_enable_latch) else $error("write enable did not set latch");
    a_wel_clear_cmd: assert property (
        state == NSF_OPCODE && byte_done && rx_byte == NSF_OP_WR_DIS && !core_stat.busy
        |=> !cfg.write_enable_latch) else $error("write disable did not clear latch");
    a_wel_write_hold: assert property (
        wr_strobe |=> $stable(cfg.write_enable_latch))
        else $error("feature write moved the latch");
    a_reset_keeps_cfg: assert property (
        state == NSF_OPCODE && byte_done && rx_byte == NSF_OP_RESET_A
        |=> $stable(cfg) && reset_cmd) else $error("reset opcode changed settings");
    a_guard_blocks_lock: assert property (
        wr_strobe && addr == NSF_OFS_LOCK && guard_locked
        |=> $stable(cfg.lock_range) && $stable(cfg.lock_write_guard))
        else $error("guarded lock field was written");
    a_lock_range_store: assert property (
        wr_strobe && addr == NSF_OFS_LOCK && !guard_locked
        |=> cfg.lock_range == $past(rx_byte[5:3]))
        else $error("lock range not stored");
    a_config_store: assert property (
        wr_strobe && addr == NSF_OFS_CONFIG
        |=> cfg.ecc_enable == $past(rx_byte[4]) && cfg.fast_read_enable == $past(rx_byte[1]))
        else $error("config byte not stored");
    a_lock_reserved_zero: assert property (
        addr == NSF_OFS_LOCK |-> (rd_byte & 8'h47) == 8'h00)
        else $error("reserved lock bits not zero");
    a_bbi_reads_one: assert property (
        addr == NSF_OFS_CONFIG |-> rd_byte[2] && !rd_byte[5] && !rd_byte[3] && !rd_byte[0])
        else $error("config readback wrong");
    a_busy_live: assert property (
        addr == NSF_OFS_STATUS |-> rd_byte[0] == core_stat.busy && rd_byte[7:6] == 2'b00)
        else $error("status busy not live");
    a_so_quiet: assert property (
        !cs_active |=> so_oe_n [*2]) else $error("so driven outside frame");

    c_set_feature: cover property (wr_strobe && addr == NSF_OFS_CONFIG);
    c_get_repeat: cover property (state == NSF_RDATA && byte_done ##[1:200] byte_done);
    c_guard_reject: cover property (wr_strobe && guard_locked);
    c_wel_set: cover property (state == NSF_OPCODE && byte_done && rx_byte == NSF_OP_WR_EN);
endmodule : nsf_feature_table

/* File: rtl/nsf_shifter.sv */
// Purpose: serial byte shifter, mode 0 style (sample on rise, shift on fall)
// Assumes: sck and si already synchronised to clk_sys
// Notes: sck must be slower than about clk_sys/6 for edges to be seen
`timescale 1ns/1ps
module nsf_shifter
    import nsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic frame_active,
    input wire logic sck_level,
    input wire logic si_level,
    input wire logic tx_load_en,
    input wire logic [7:0] tx_load_byte,
    output logic [7:0] rx_byte,
    output logic byte_done,
    output logic tx_bit
);
    logic sck_prev;
    logic [2:0] bit_cnt;
    logic [7:0] tx_shift;
    logic rise;
    logic fall;
    logic next_sck_prev;
    logic [2:0] next_bit_cnt;
    logic [7:0] next_rx_byte;
    logic [7:0] next_tx_shift;
    logic next_byte_done;

    assign rise = sck_level && !sck_prev;
    assign fall = !sck_level && sck_prev;
    assign tx_bit = tx_shift[7];

    // a fresh byte is loaded at the fall that ends the previous byte, so live data goes out
    always_comb begin
        next_sck_prev = sck_level;
        next_bit_cnt = bit_cnt;
        next_rx_byte = rx_byte;
        next_tx_shift = tx_shift;
        next_byte_done = 1'b0;
        if (!frame_active) begin
            next_bit_cnt = 3'h0;
            next_tx_shift = 8'h00;
        end else begin
            if (rise) begin
                next_rx_byte = {rx_byte[6:0], si_level};
                next_bit_cnt = bit_cnt + 3'h1;
                next_byte_done = (bit_cnt == NSF_LAST_BIT);
            end
            if (fall) begin
                if (bit_cnt == 3'h0 && tx_load_en) begin
                    next_tx_shift = tx_load_byte;
                end else begin
                    next_tx_shift = {tx_shift[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sck_prev <= 1'b0;
            bit_cnt <= 3'h0;
            rx_byte <= 8'h00;
            tx_shift <= 8'h00;
            byte_done <= 1'b0;
        end else begin
            sck_prev <= next_sck_prev;
            bit_cnt <= next_bit_cnt;
            rx_byte <= next_rx_byte;
            tx_shift <= next_tx_shift;
            byte_done <= next_byte_done;
        end
    end
endmodule : nsf_shifter

/* File: rtl/nsf_sync.sv */
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are levels from outside the clk_sys domain
// Notes: only sync_out may be read by other logic
`timescale 1ns/1ps
module nsf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // first stage feeds only the second
    always_comb begin
        next_meta = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule : nsf_sync
